/* hw/pspc_pkg.sv */
// Package for the probe pin and security fuse control block.
// Assumes a 32-bit APB register bus and a single 10 MHz core clock.
package pspc_pkg;

  //////////////////////////////////////////////////////////////////////////////
  // Register byte offsets
  localparam logic [7:0] PSPC_CTRL_OFS = 8'h00;
  localparam logic [7:0] PSPC_STATUS_OFS = 8'h04;
  localparam logic [7:0] PSPC_PROG_OFS = 8'h08;
  localparam logic [7:0] PSPC_SHIFT_OFS = 8'h0c;

  // Control fields
  localparam int PSPC_CTRL_MODE_LSB = 0;
  localparam int PSPC_CTRL_LATCH_BIT = 2;
  localparam logic [2:0] PSPC_CTRL_RST = 3'h0;

  // Status fields
  localparam int PSPC_ST_MODE_BIT = 0;
  localparam int PSPC_ST_DIS_BIT = 1;
  localparam int PSPC_ST_LOCK_BIT = 2;
  localparam int PSPC_ST_PROBE_BIT = 3;
  localparam int PSPC_ST_REFUSED_BIT = 4;
  localparam int PSPC_ST_TWO_FUSE_BIT = 5;
  localparam int PSPC_ST_OE_LSB = 8;

  // Program request fields
  localparam int PSPC_PROG_DIS_BIT = 0;
  localparam int PSPC_PROG_LOCK_BIT = 1;
  localparam int PSPC_PROG_ARRAY_BIT = 2;

  // Shift capture
  localparam int PSPC_SHIFT_W = 8;
  localparam int PSPC_SHIFT_CNT_LSB = 16;

  //////////////////////////////////////////////////////////////////////////////
  typedef enum logic [1:0] {
    PSPC_PROBE_OFF = 2'b00,
    PSPC_CHANNEL_A_PROBE_MODE = 2'b01,
    PSPC_CHANNEL_B_PROBE_MODE = 2'b10,
    PSPC_DUAL_CHANNEL_PROBE_MODE = 2'b11
  } pspc_probe_mode_t;

  typedef enum logic [0:0] {
    PSPC_APB_IDLE = 1'b0,
    PSPC_APB_RESP = 1'b1
  } pspc_apb_state_t;

  // One bit for each of the four shared pins
  typedef struct packed {
    logic shift_clock;
    logic serial_in;
    logic pin_b;
    logic pin_a;
  } pspc_pins_t;

endpackage

/* hw/pspc_top.sv */
// Probe pin and security fuse control: pin roles, probe capture, APB regs.
// Assumes pins, MODE_SEL and fuse levels are asynchronous; user and probe
// data inputs come from logic on CORE_CLK.
//
// Operation
// RULE1 - Two-fuse variant has a probe-disable fuse and a program-lock fuse.
// RULE2 - Programmed probe-disable fuse shuts off all probe circuitry permanently.
// RULE3 - Programmed lock fuse refuses every further fuse programming request.
// RULE4 - Normal mode: undefined pins become driven-low outputs, two-fuse serial/clock excepted.
// RULE5 - Two-fuse: undefined serial/clock pins are inputs until lock, then driven low.
// RULE6 - Board ties undefined serial/clock pins to ground while unlocked.
// RULE7 - Mode select low is normal operation, high is probe mode.
// RULE8 - Two-fuse normal mode: A/B user I/O; serial/clock input only unless locked.
// RULE9 - Serial/clock pins may drive only after the lock fuse is programmed.
// RULE10 - Two-fuse probe mode: probe roles unless disable fuse set, then all disabled.
// RULE11 - Probe outputs share pins via mux; mode register picks A, B or both.
// RULE12 - Channel A mode: A drives pin, user output off, input kept; B user.
// RULE13 - Channel B mode mirrors channel A mode.
// RULE14 - Dual mode: both probe outputs drive, both user outputs off, inputs kept.
// RULE15 - Optional input latch holds user input while a pin is probed.
// RULE16 - Serial/clock pins feed probe and user input paths in parallel.
// RULE17 - Probe tool must not drive serial/clock pins whose user output is on.
// RULE18 - Single-fuse variant has one fuse that disables probe circuitry.
// RULE19 - Single-fuse: undefined serial/clock driven low unfused; normal mode all user I/O.
// RULE20 - Single-fuse probe mode: probe roles, or all four inputs once fused.
// RULE21 - Single-fuse: input latch present; probe mode inhibits serial/clock user outputs.
// RULE22 - Pin roles follow mode select, fuse levels and the probe mode setting.
//
// Chosen here: the APB register port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none

module pspc_top #(
  parameter bit TWO_FUSE = 1'b1,
  parameter int SHIFT_W = pspc_pkg::PSPC_SHIFT_W
) (
  // Clock and reset
  input wire logic CORE_CLK,
  input wire logic RST_N,
  // APB slave
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  // Configuration pins and fuse levels
  input wire logic MODE_SEL,
  input wire logic FUSE_PROBE_DIS,
  input wire logic FUSE_PROG_LOCK,
  // Shared device pins
  input wire pspc_pkg::pspc_pins_t PIN_I,
  output pspc_pkg::pspc_pins_t PIN_O,
  output pspc_pkg::pspc_pins_t PIN_OE,
  // User design side
  input wire pspc_pkg::pspc_pins_t USER_DEF,
  input wire pspc_pkg::pspc_pins_t USER_O,
  input wire pspc_pkg::pspc_pins_t USER_OE,
  output pspc_pkg::pspc_pins_t USER_IN,
  // Probe circuitry side
  input wire logic PROBE_A,
  input wire logic PROBE_B,
  output logic PROBE_SERIAL_IN,
  output logic PROBE_SHIFT_CLOCK,
  output logic PROBE_SHIFT_STB,
  // Fuse programming strobes
  output logic [2:0] FUSE_PGM
);
  import pspc_pkg::*;

  localparam int NSYNC = 7;

  ////////////////////////////////////////////////////////////////////////////
  // Synchronisers for everything from outside the clock domain
  logic [NSYNC-1:0] sync_in;
  logic [NSYNC-1:0] sync_1;
  logic [NSYNC-1:0] sync_2;

  assign sync_in = {FUSE_PROG_LOCK, FUSE_PROBE_DIS, MODE_SEL, PIN_I};

  genvar gi;
  generate
    for (gi = 0; gi < NSYNC; gi++) begin : g_sync
      always_ff @(posedge CORE_CLK) begin
        if (!RST_N) begin
          sync_1[gi] <= 1'b0;
          sync_2[gi] <= 1'b0;
        end else begin
          sync_1[gi] <= sync_in[gi];
          sync_2[gi] <= sync_1[gi];
        end
      end
    end
  endgenerate

  pspc_pins_t pin_q;
  logic mode_q;
  logic dis_q;
  logic lock_q;
  logic io_free;
  logic probe_on;

  assign pin_q = sync_2[3:0];
  assign mode_q = sync_2[4]; // [RULE7]
  // Security fuse of the single-fuse part arrives on the disable input
  assign dis_q = sync_2[5]; // [RULE1] [RULE18]
  assign lock_q = TWO_FUSE ? sync_2[6] : 1'b0; // [RULE1]
  // Single-fuse part needs no fuse to free the serial/clock pins
  assign io_free = TWO_FUSE ? lock_q : 1'b1; // [RULE19]
  assign probe_on = mode_q && !dis_q; // [RULE2] [RULE10] [RULE20]

  ////////////////////////////////////////////////////////////////////////////
  // Control register state
  pspc_probe_mode_t probe_mode;
  logic latch_en;
  logic refused;
  logic [SHIFT_W-1:0] shift_data;
  logic [7:0] shift_cnt;
  pspc_apb_state_t apb_state;

  // Register index decode for the write path; reg_hit shared by read and write paths
  function automatic logic [1:0] reg_index(input logic [7:0] addr);
    case (addr)
      PSPC_CTRL_OFS: reg_index = 2'h0;
      PSPC_STATUS_OFS: reg_index = 2'h1;
      PSPC_PROG_OFS: reg_index = 2'h2;
      default: reg_index = 2'h3;
    endcase
  endfunction

  function automatic logic reg_hit(input logic [7:0] addr);
    reg_hit = (addr == PSPC_CTRL_OFS) || (addr == PSPC_STATUS_OFS) ||
              (addr == PSPC_PROG_OFS) || (addr == PSPC_SHIFT_OFS);
  endfunction

  // Pin driven by user design, or parked low when the design leaves it open
  function automatic logic [1:0] user_drive(input logic def, input logic o, input logic oe);
    user_drive = def ? {o, oe} : 2'b01; // [RULE4]
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // APB slave: one wait-free access phase, pready raised from the setup cycle
  logic setup;
  logic wr_en;
  logic [1:0] wr_idx;

  assign setup = PSEL && !PENABLE;
  assign wr_en = PSEL && PENABLE && PREADY && PWRITE && reg_hit(PADDR);
  assign wr_idx = reg_index(PADDR);

  always_ff @(posedge CORE_CLK) begin
    if (!RST_N) begin
      apb_state <= PSPC_APB_IDLE;
      PREADY <= 1'b0;
    end else begin
      case (apb_state)
        PSPC_APB_IDLE: begin
          if (setup) begin
            apb_state <= PSPC_APB_RESP;
            PREADY <= 1'b1;
          end
        end
        PSPC_APB_RESP: begin
          apb_state <= PSPC_APB_IDLE;
          PREADY <= 1'b0;
        end
        default: begin
          apb_state <= PSPC_APB_IDLE;
          PREADY <= 1'b0;
        end
      endcase
    end
  end

  logic [31:0] next_rdata;

  always_comb begin
    next_rdata = 32'h0;
    case (PADDR)
      PSPC_CTRL_OFS: begin
        next_rdata[PSPC_CTRL_MODE_LSB +: 2] = probe_mode;
        next_rdata[PSPC_CTRL_LATCH_BIT] = latch_en;
      end
      PSPC_STATUS_OFS: begin
        next_rdata[PSPC_ST_MODE_BIT] = mode_q;
        next_rdata[PSPC_ST_DIS_BIT] = dis_q;
        next_rdata[PSPC_ST_LOCK_BIT] = lock_q;
        next_rdata[PSPC_ST_PROBE_BIT] = probe_on;
        next_rdata[PSPC_ST_REFUSED_BIT] = refused;
        next_rdata[PSPC_ST_TWO_FUSE_BIT] = TWO_FUSE;
        next_rdata[PSPC_ST_OE_LSB +: 4] = PIN_OE;
      end
      PSPC_SHIFT_OFS: begin
        next_rdata[SHIFT_W-1:0] = shift_data;
        next_rdata[PSPC_SHIFT_CNT_LSB +: 8] = shift_cnt;
      end
      default: next_rdata = 32'h0;
    endcase
  end

  always_ff @(posedge CORE_CLK) begin
    if (!RST_N) begin
      PRDATA <= 32'h0;
      PSLVERR <= 1'b0;
    end else if (setup && apb_state == PSPC_APB_IDLE) begin
      PRDATA <= PWRITE ? 32'h0 : next_rdata;
      PSLVERR <= !reg_hit(PADDR);
    end else if (!PSEL) begin
      PRDATA <= 32'h0;
      PSLVERR <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Control register
  always_ff @(posedge CORE_CLK) begin
    if (!RST_N) begin
      probe_mode <= pspc_probe_mode_t'(PSPC_CTRL_RST[1:0]);
      latch_en <= PSPC_CTRL_RST[PSPC_CTRL_LATCH_BIT];
    end else if (wr_en && wr_idx == 2'h0) begin
      probe_mode <= pspc_probe_mode_t'(PWDATA[PSPC_CTRL_MODE_LSB +: 2]); // [RULE11]
      latch_en <= PWDATA[PSPC_CTRL_LATCH_BIT];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Fuse programming; a locked part only records the refusal
  logic prog_wr;
  logic [2:0] prog_req;

  assign prog_wr = wr_en && wr_idx == 2'h2;
  // No lock fuse exists on the single-fuse part
  assign prog_req = {PWDATA[PSPC_PROG_ARRAY_BIT],
                     PWDATA[PSPC_PROG_LOCK_BIT] && TWO_FUSE,
                     PWDATA[PSPC_PROG_DIS_BIT]};

  always_ff @(posedge CORE_CLK) begin
    if (!RST_N) begin
      FUSE_PGM <= 3'h0;
    end else if (prog_wr && !lock_q) begin
      FUSE_PGM <= prog_req;
    end else begin
      FUSE_PGM <= 3'h0; // [RULE3]
    end
  end

  // Sticky refusal flag, write one to clear; a new refusal beats the clear
  always_ff @(posedge CORE_CLK) begin
    if (!RST_N) begin
      refused <= 1'b0;
    end else if (prog_wr && lock_q && (prog_req != 3'h0)) begin
      refused <= 1'b1; // [RULE3]
    end else if (wr_en && wr_idx == 2'h1 && PWDATA[PSPC_ST_REFUSED_BIT]) begin
      refused <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pin role selection
  pspc_pins_t next_o;
  pspc_pins_t next_oe;
  logic probe_a_sel;
  logic probe_b_sel;

  assign probe_a_sel = probe_on && (probe_mode == PSPC_CHANNEL_A_PROBE_MODE ||
                                    probe_mode == PSPC_DUAL_CHANNEL_PROBE_MODE);
  assign probe_b_sel = probe_on && (probe_mode == PSPC_CHANNEL_B_PROBE_MODE ||
                                    probe_mode == PSPC_DUAL_CHANNEL_PROBE_MODE);

  always_comb begin
    next_o = '0;
    next_oe = '0;
    // Pin A
    if (probe_a_sel) begin
      {next_o.pin_a, next_oe.pin_a} = {PROBE_A, 1'b1}; // [RULE12] [RULE14]
    end else if (!mode_q || probe_on) begin
      {next_o.pin_a, next_oe.pin_a} = user_drive(USER_DEF.pin_a, USER_O.pin_a,
                                                 USER_OE.pin_a); // [RULE8] [RULE13]
    end
    // Pin B
    if (probe_b_sel) begin
      {next_o.pin_b, next_oe.pin_b} = {PROBE_B, 1'b1}; // [RULE13] [RULE14]
    end else if (!mode_q || probe_on) begin
      {next_o.pin_b, next_oe.pin_b} = user_drive(USER_DEF.pin_b, USER_O.pin_b,
                                                 USER_OE.pin_b); // [RULE8] [RULE12]
    end
    // Serial and clock pins stay inputs in probe mode, so no driver
    // can fight the external tool; user outputs are unseen meanwhile
    if (!mode_q && io_free) begin
      {next_o.serial_in, next_oe.serial_in} = user_drive(USER_DEF.serial_in,
          USER_O.serial_in, USER_OE.serial_in); // [RULE5] [RULE9] [RULE19]
      {next_o.shift_clock, next_oe.shift_clock} = user_drive(USER_DEF.shift_clock,
          USER_O.shift_clock, USER_OE.shift_clock); // [RULE5] [RULE9] [RULE19]
    end
  end

  // Pins registered so the bus never sees a combinational glitch
  always_ff @(posedge CORE_CLK) begin
    if (!RST_N) begin
      PIN_O <= '0;
      PIN_OE <= '0;
    end else begin
      PIN_O <= next_o; // [RULE22]
      PIN_OE <= next_oe; // [RULE10] [RULE20] [RULE21]
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // User input path, always live; optional hold while a pin is probed
  pspc_pins_t hold;

  assign hold.pin_a = latch_en && probe_a_sel; // [RULE15]
  assign hold.pin_b = latch_en && probe_b_sel; // [RULE15]
  assign hold.serial_in = latch_en && !TWO_FUSE && mode_q; // [RULE21]
  assign hold.shift_clock = latch_en && !TWO_FUSE && mode_q; // [RULE21]

  generate
    for (gi = 0; gi < 4; gi++) begin : g_uin
      always_ff @(posedge CORE_CLK) begin
        if (!RST_N) begin
          USER_IN[gi] <= 1'b0;
        end else if (!hold[gi]) begin
          USER_IN[gi] <= pin_q[gi]; // [RULE16]
        end
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // Probe serial path; shift clock edges found by oversampling
  logic clk_d;
  logic clk_rise;

  assign clk_rise = pin_q.shift_clock && !clk_d;

  always_ff @(posedge CORE_CLK) begin
    if (!RST_N) begin
      clk_d <= 1'b0;
    end else begin
      clk_d <= pin_q.shift_clock;
    end
  end

  always_ff @(posedge CORE_CLK) begin
    if (!RST_N) begin
      PROBE_SERIAL_IN <= 1'b0;
      PROBE_SHIFT_CLOCK <= 1'b0;
      PROBE_SHIFT_STB <= 1'b0;
    end else begin
      PROBE_SERIAL_IN <= probe_on && pin_q.serial_in; // [RULE16] [RULE2]
      PROBE_SHIFT_CLOCK <= probe_on && pin_q.shift_clock; // [RULE16]
      PROBE_SHIFT_STB <= probe_on && clk_rise; // [RULE2]
    end
  end

  // Capture of the serial stream, readable for diagnosis
  always_ff @(posedge CORE_CLK) begin
    if (!RST_N) begin
      shift_data <= '0;
      shift_cnt <= 8'h0;
    end else if (probe_on && clk_rise) begin
      shift_data <= {shift_data[SHIFT_W-2:0], pin_q.serial_in};
      shift_cnt <= shift_cnt + 8'h1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (!RST_N);

  probe_dis_quiet_a: assert property (mode_q && dis_q && TWO_FUSE |=>
      PIN_OE == '0 && !PROBE_SHIFT_STB) // [RULE2] [RULE10]
    else $error("probe pins active with disable fuse set");

  lock_refuse_a: assert property (prog_wr && lock_q |=> FUSE_PGM == 3'h0 ##0
      (refused || $past(prog_req) == 3'h0)) // [RULE3]
    else $error("fuse programmed while locked");

  undef_low_a: assert property (!mode_q && !USER_DEF.pin_a |=>
      PIN_OE.pin_a && !PIN_O.pin_a) // [RULE4]
    else $error("undefined pin not driven low");

  unlocked_input_a: assert property (TWO_FUSE && !lock_q |=>
      !PIN_OE.serial_in && !PIN_OE.shift_clock) // [RULE5] [RULE9]
    else $error("serial pin driven before lock");

  chan_a_drive_a: assert property (probe_on &&
      probe_mode == PSPC_CHANNEL_A_PROBE_MODE && USER_DEF.pin_b |=>
      PIN_OE.pin_a && PIN_O.pin_a == $past(PROBE_A) &&
      PIN_OE.pin_b == $past(USER_OE.pin_b)) // [RULE12]
    else $error("channel A mode pin roles wrong");

  dual_drive_a: assert property (probe_on &&
      probe_mode == PSPC_DUAL_CHANNEL_PROBE_MODE |=>
      PIN_OE.pin_a && PIN_OE.pin_b && PIN_O.pin_b == $past(PROBE_B)) // [RULE14]
    else $error("dual mode not driving both pins");

  probe_serial_in_a: assert property (mode_q |=> !PIN_OE.serial_in &&
      !PIN_OE.shift_clock) // [RULE21] [RULE20]
    else $error("serial pins driven in probe mode");

  shift_strobe_a: assert property ($rose(PROBE_SHIFT_STB) |->
      $past(probe_on) && $past(pin_q.shift_clock) && !$past(clk_d)) // [RULE16]
    else $error("shift strobe without clock edge");

  apb_ready_a: assert property (setup && apb_state == PSPC_APB_IDLE |=>
      PREADY ##1 !PREADY)
    else $error("apb ready not a single cycle");

  user_in_follow_a: assert property (!latch_en |=> ##1
      USER_IN.serial_in == $past(pin_q.serial_in)) // [RULE16]
    else $error("user input path not live");

endmodule

`default_nettype wire

/* sim/pspc_probe_tool.sv */
// Probe tool model: shifts a byte in, MSB first, on its own slow clock.
// Assumes the board pulls both lines to ground whenever the tool is idle.
`timescale 1ns/1ps
`default_nettype none

module pspc_probe_tool (
  // Tool-driven lines
  output logic serial_line,
  output logic clock_line
);
  // Idle low, clock stands still between frames
  initial begin
    serial_line = 1'b0;
    clock_line = 1'b0;
  end

  // Caller starts frames only in probe mode with user outputs off
  task automatic send(input logic [7:0] b);
    for (int i = 7; i >= 0; i--) begin
      serial_line = b[i];
      #400 clock_line = 1'b1;
      #400 clock_line = 1'b0;
    end
    serial_line = 1'b0;
  endtask
endmodule

`default_nettype wire

/* sim/test_probe_pin_security_control.sv */
// Bench: pin roles of both fuse variants, fuse strobes, probe capture, APB regs.
// Assumes pspc_pkg and pspc_top are compiled first; one tool model on the pins.
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin error_cnt++; \
  $display("ERROR t=%0t got=%h exp=%h", $time, a, b); end end

module test_probe_pin_security_control;
  import pspc_pkg::*;
  logic clk, rst_n, psel, penable, pwrite, mode, dis, lock, prb_a, prb_b;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic pready, pslverr, er, pser, pclk, stb, tser, tclk;
  logic [3:0] udef, uo, uoe, ext4, pin_o, pin_oe, pin_i, uin, pin_o2, pin_oe2, pin_i2;
  logic [1:0] ext;
  logic [2:0] pgm, pgm_seen;
  logic [7:0] r, r2, sb;
  int error_cnt = 0, checks_done = 0, stb_cnt = 0;

  assign ext4 = {tclk, tser, ext};
  assign pin_i = (pin_oe & pin_o) | (~pin_oe & ext4);
  assign pin_i2 = (pin_oe2 & pin_o2) | (~pin_oe2 & ext4);

  pspc_top #(.TWO_FUSE(1'b1)) pspc_top_i (.CORE_CLK(clk), .RST_N(rst_n), .PSEL(psel),
    .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata),
    .PREADY(pready), .PSLVERR(pslverr), .MODE_SEL(mode), .FUSE_PROBE_DIS(dis),
    .FUSE_PROG_LOCK(lock), .PIN_I(pin_i), .PIN_O(pin_o), .PIN_OE(pin_oe), .USER_DEF(udef),
    .USER_O(uo), .USER_OE(uoe), .USER_IN(uin), .PROBE_A(prb_a), .PROBE_B(prb_b),
    .PROBE_SERIAL_IN(pser), .PROBE_SHIFT_CLOCK(pclk), .PROBE_SHIFT_STB(stb), .FUSE_PGM(pgm));
  // Single-fuse variant shares every input but PIN_I, fed from its own pin loopback; only its pin roles are judged
  pspc_top #(.TWO_FUSE(1'b0)) pspc_top_1f_i (.CORE_CLK(clk), .RST_N(rst_n), .PSEL(psel),
    .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(),
    .PREADY(), .PSLVERR(), .MODE_SEL(mode), .FUSE_PROBE_DIS(dis),
    .FUSE_PROG_LOCK(lock), .PIN_I(pin_i2), .PIN_O(pin_o2), .PIN_OE(pin_oe2), .USER_DEF(udef),
    .USER_O(uo), .USER_OE(uoe), .USER_IN(), .PROBE_A(prb_a), .PROBE_B(prb_b),
    .PROBE_SERIAL_IN(), .PROBE_SHIFT_CLOCK(), .PROBE_SHIFT_STB(), .FUSE_PGM());
  pspc_probe_tool pspc_probe_tool_i (.serial_line(tser), .clock_line(tclk));

  ////////////////////////////////////////////////////////////////////////////
  // Expected {oe, o} of the four pins
  function automatic logic [7:0] roles(input logic two, m, d, l, input logic [1:0] pm,
      input logic [3:0] df, o_u, oe_u, input logic pa, pb);
    logic [3:0] oe, o;
    logic act, usr;
    act = m & !d;
    for (int k = 0; k < 4; k++) begin
      usr = (k < 2) ? (!m || act) : !(m || (two && !l));
      oe[k] = usr & (df[k] ? oe_u[k] : 1'b1);
      o[k] = usr & df[k] & o_u[k];
    end
    if (act && pm[0]) {oe[0], o[0]} = {1'b1, pa};
    if (act && pm[1]) {oe[1], o[1]} = {1'b1, pb};
    return {oe, o};
  endfunction

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    // Request stands until pready is seen high at a rising edge
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) error_cnt++;
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic conclude;
    $display("Checks %0d errors %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  always @(posedge clk) begin
    pgm_seen <= pgm_seen | pgm;
    if (stb === 1'b1) stb_cnt++;
  end

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  initial begin
    #3000000;
    error_cnt++;
    conclude();
  end

  initial begin
    {rst_n, psel, penable, pwrite, mode, dis, lock, prb_a, prb_b} = '0;
    {paddr, pwdata, udef, uo, uoe, ext, pgm_seen} = '0;
    void'($urandom(32'h9473));
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    apb(1'b0, PSPC_CTRL_OFS, 32'h0);
    `CHK(rd, 32'h0)
    apb(1'b0, 8'h10, 32'h0);
    `CHK({er, rd}, {1'b1, 32'h0})
    // Every mode/fuse/probe-mode combination, random user and probe data
    for (int i = 0; i < 64; i++) begin
      @(posedge clk);
      {lock, dis, mode} <= i[2:0];
      udef <= 4'($urandom);
      uo <= 4'($urandom);
      uoe <= 4'($urandom);
      {prb_a, prb_b, ext} <= 4'($urandom);
      apb(1'b1, PSPC_CTRL_OFS, {30'h0, i[4:3]});
      repeat (6) @(negedge clk);
      r = roles(1'b1, mode, dis, lock, i[4:3], udef, uo, uoe, prb_a, prb_b);
      r2 = roles(1'b0, mode, dis, lock, i[4:3], udef, uo, uoe, prb_a, prb_b);
      `CHK(pin_oe, r[7:4])
      `CHK(pin_o & pin_oe, r[7:4] & r[3:0])
      `CHK(pin_oe2, r2[7:4])
      `CHK(pin_o2 & pin_oe2, r2[7:4] & r2[3:0])
      `CHK(uin, (r[7:4] & r[3:0]) | (~r[7:4] & ext4))
      apb(1'b0, PSPC_STATUS_OFS, 32'h0);
      `CHK({rd[11:8], rd[5:0] & 6'h2f}, {r[7:4], 2'b10, mode & !dis, lock, dis, mode})
    end
    // Fuse strobes while unlocked, then refused once locked
    @(posedge clk);
    {mode, dis, lock} <= 3'b000;
    for (int b = 0; b < 3; b++) begin
      pgm_seen <= 3'h0;
      apb(1'b1, PSPC_PROG_OFS, 32'h1 << b);
      repeat (3) @(negedge clk);
      `CHK(pgm_seen, 3'(1 << b))
    end
    @(posedge clk);
    lock <= 1'b1;
    repeat (5) @(posedge clk);
    pgm_seen <= 3'h0;
    apb(1'b1, PSPC_PROG_OFS, 32'h7);
    repeat (3) @(negedge clk);
    `CHK(pgm_seen, 3'h0)
    apb(1'b0, PSPC_STATUS_OFS, 32'h0);
    `CHK(rd[4], 1'b1)
    apb(1'b1, PSPC_STATUS_OFS, 32'h10);
    apb(1'b0, PSPC_STATUS_OFS, 32'h0);
    `CHK(rd[4], 1'b0)
    // Probe frames: captured when enabled, ignored once the disable fuse is set
    @(posedge clk);
    {mode, lock} <= 2'b10;
    repeat (6) @(negedge clk);
    `CHK(pin_oe[3:2], 2'b00)
    for (int f = 0; f < 2; f++) begin
      @(posedge clk);
      dis <= f[0];
      repeat (5) @(posedge clk);
      stb_cnt = 0;
      apb(1'b0, PSPC_SHIFT_OFS, 32'h0);
      r = rd[23:16];
      r2 = rd[7:0];
      sb = 8'($urandom);
      pspc_probe_tool_i.send(sb);
      repeat (6) @(posedge clk);
      apb(1'b0, PSPC_SHIFT_OFS, 32'h0);
      `CHK(stb_cnt, f ? 0 : 8)
      `CHK(rd[23:16], 8'(r + (f ? 0 : 8)))
      `CHK(rd[7:0], f ? r2 : sb)
    end
    conclude();
  end
endmodule

`default_nettype wire
